// ==== pkg/acg_pkg.sv ====
// package: register layouts, reset values and timing constants for the config bank
//
// Behaviour
// - readback selector picks interface or internal coefficient
// - system gain disable drops system gain coefficient
// - system offset disable drops system offset coefficient
// - self gain disable drops self gain coefficient
// - self offset disable drops self offset coefficient
// - pin1 function select: one gpio, zero sync
// - pin0 function select: one gpio, zero clock
// - direction bits: one output, zero input
// - output drives value bit; input reads pin
// - channel switch delay is value times 4us
// - output pin delay is value times 20us
package acg_pkg;

  // register select codes on the host register port
  localparam logic [1:0] REG_CAL_CTRL  = 2'h0;
  localparam logic [1:0] REG_GPIO_CTRL = 2'h1;
  localparam logic [1:0] REG_DELAY     = 2'h2;

  // calibration_control field positions
  localparam int CAL_SEL_BIT  = 4;
  localparam int SYS_G_BIT    = 3;
  localparam int SYS_O_BIT    = 2;
  localparam int SELF_G_BIT   = 1;
  localparam int SELF_O_BIT   = 0;
  localparam logic [4:0] CAL_CTRL_RESET = 5'h1C;

  // general_io_control field positions
  localparam int PIN1_FN_BIT  = 7;
  localparam int PIN0_FN_BIT  = 6;
  localparam int DIR_LSB      = 3;
  localparam int VAL_LSB      = 0;
  localparam logic [7:0] GPIO_CTRL_RESET = 8'h40;

  // settle_delay field positions
  localparam int SW_DLY_LSB   = 8;
  localparam int PIN_DLY_LSB  = 0;
  localparam logic [15:0] DELAY_RESET = 16'h0000;

  // timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int SW_STEP_NS   = 4000;
  localparam int PIN_STEP_NS  = 20000;
  localparam int SW_STEP_CYC  = (SW_STEP_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int PIN_STEP_CYC = (PIN_STEP_NS * (CLK_HZ / 1_000_000)) / 1000;

endpackage

// ==== hw/acg_settle_timer.sv ====
// settle delay timer: waits value times step cycles after a start pulse
`timescale 1ns/1ps
module acg_settle_timer #(
  parameter int STEP_CYC = 40
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [7:0] steps,
  output logic            busy,
  output logic            done
);
  typedef struct packed {
    logic [7:0]  step_cnt;
    logic [15:0] cyc_cnt;
    logic        busy;
    logic        done;
  } acg_tmr_s;

  acg_tmr_s st_r;
  acg_tmr_s st_nxt;

  // steps counted in whole clock cycles, exact at 10 MHz
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (start) begin
      if (steps == 8'h00) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.busy     = 1'b1;
        st_nxt.step_cnt = steps;
        st_nxt.cyc_cnt  = 16'(STEP_CYC - 1);
      end
    end else if (st_r.busy) begin
      if (st_r.cyc_cnt != 16'h0000) begin
        st_nxt.cyc_cnt = st_r.cyc_cnt - 16'h0001;
      end else if (st_r.step_cnt == 8'h01) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.step_cnt = st_r.step_cnt - 8'h01;
        st_nxt.cyc_cnt  = 16'(STEP_CYC - 1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;
endmodule

// ==== hw/acg_pin_sync.sv ====
// two-flop synchroniser, WIDTH bits wide: the three gpio pin inputs or the single sync pin
`timescale 1ns/1ps
module acg_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } acg_sync_s;

  acg_sync_s st_r;
  acg_sync_s st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt.meta   = pin_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.stable;
endmodule

// ==== hw/acg_config_bank.sv ====
// calibration select, gpio control and settle delay configuration bank
`timescale 1ns/1ps
module acg_config_bank (
  input  wire logic        core_clk,
  input  wire logic        reset,
  // register port from the serial interface
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_sel,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // calibration coefficient readback
  input  wire logic [23:0] cal_if_value,
  input  wire logic [23:0] cal_int_value,
  output logic      [23:0] cal_read_value,
  // calibration enables toward the correction datapath
  output logic             sys_gain_apply,
  output logic             sys_offset_apply,
  output logic             self_gain_apply,
  output logic             self_offset_apply,
  // shared pin function
  output logic             pin1_is_gpio,
  output logic             pin0_is_gpio,
  input  wire logic        sync_pin_in,
  output logic             sync_in,
  // gpio pads
  input  wire logic [2:0]  gpio_in,
  output logic      [2:0]  gpio_out,
  output logic      [2:0]  gpio_oe,
  // settle delays
  input  wire logic        chan_switch_start,
  output logic             chan_switch_done,
  input  wire logic        out_pin_start,
  output logic             out_pin_done
);
  typedef struct packed {
    logic [4:0]  cal_ctrl;
    logic [7:0]  gpio_ctrl;
    logic [15:0] delay;
    logic [15:0] rdata;
    logic        rvalid;
    logic [23:0] cal_read;
    logic [3:0]  cal_apply;
    logic [1:0]  pin_fn;
    logic        sync_in;
    logic [2:0]  gpio_out;
    logic [2:0]  gpio_oe;
    logic        sw_done;
    logic        pin_done;
  } acg_bank_s;

  acg_bank_s st_r;
  acg_bank_s st_nxt;

  logic [2:0] gpio_sync;
  logic [2:0] sync_raw;
  logic       sync_level;
  logic       sw_done_w;
  logic       pin_done_w;
  logic [2:0] dir;
  logic [2:0] val;

  // pad levels get their own synchroniser; the sync pin has a second one
  assign sync_raw = gpio_in;

  acg_pin_sync #(
    .WIDTH(3)
  ) u_gpio_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (sync_raw),
    .pin_sync (gpio_sync)
  );

  // single bit wide, so no idle flops sit beside the sync pin
  acg_pin_sync #(
    .WIDTH(1)
  ) u_sync_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (sync_pin_in),
    .pin_sync (sync_level)
  );

  acg_settle_timer #(
    .STEP_CYC(acg_pkg::SW_STEP_CYC)
  ) u_sw_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (chan_switch_start),
    .steps    (st_r.delay[acg_pkg::SW_DLY_LSB +: 8]),
    .busy     (),
    .done     (sw_done_w)
  );

  acg_settle_timer #(
    .STEP_CYC(acg_pkg::PIN_STEP_CYC)
  ) u_pin_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (out_pin_start),
    .steps    (st_r.delay[acg_pkg::PIN_DLY_LSB +: 8]),
    .busy     (),
    .done     (pin_done_w)
  );

  assign dir = st_r.gpio_ctrl[acg_pkg::DIR_LSB +: 3];
  assign val = st_r.gpio_ctrl[acg_pkg::VAL_LSB +: 3];

  // register writes, readback and derived pin controls
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    if (reg_wr) begin
      case (reg_sel)
        acg_pkg::REG_CAL_CTRL: begin
          st_nxt.cal_ctrl = reg_wdata[4:0];
        end
        acg_pkg::REG_GPIO_CTRL: begin
          st_nxt.gpio_ctrl = reg_wdata[7:0];
        end
        acg_pkg::REG_DELAY: begin
          st_nxt.delay = reg_wdata;
        end
        default: begin
          st_nxt.delay = st_r.delay;
        end
      endcase
    end
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      case (reg_sel)
        acg_pkg::REG_CAL_CTRL: begin
          st_nxt.rdata = {11'h000, st_r.cal_ctrl};
        end
        acg_pkg::REG_GPIO_CTRL: begin
          // inputs show the pad level, outputs the stored value
          st_nxt.rdata = {8'h00, st_r.gpio_ctrl[7:3],
                          (dir & val) | (~dir & gpio_sync)};
        end
        acg_pkg::REG_DELAY: begin
          st_nxt.rdata = st_r.delay;
        end
        default: begin
          st_nxt.rdata = 16'h0000; // unmapped reads zero
        end
      endcase
    end
    // coefficient readback source
    st_nxt.cal_read = st_r.cal_ctrl[acg_pkg::CAL_SEL_BIT] ? cal_if_value
                                                          : cal_int_value;
    st_nxt.cal_apply[3] = ~st_r.cal_ctrl[acg_pkg::SYS_G_BIT];
    st_nxt.cal_apply[2] = ~st_r.cal_ctrl[acg_pkg::SYS_O_BIT];
    st_nxt.cal_apply[1] = ~st_r.cal_ctrl[acg_pkg::SELF_G_BIT];
    st_nxt.cal_apply[0] = ~st_r.cal_ctrl[acg_pkg::SELF_O_BIT];
    st_nxt.pin_fn[1] = st_r.gpio_ctrl[acg_pkg::PIN1_FN_BIT];
    st_nxt.pin_fn[0] = st_r.gpio_ctrl[acg_pkg::PIN0_FN_BIT];
    // sync input is gated off while pin1 serves as gpio
    st_nxt.sync_in = ~st_r.gpio_ctrl[acg_pkg::PIN1_FN_BIT] & sync_level;
    st_nxt.gpio_out = val & dir;
    // shared pins drive only in gpio function
    st_nxt.gpio_oe = dir & {1'b1, st_r.gpio_ctrl[acg_pkg::PIN1_FN_BIT],
                            st_r.gpio_ctrl[acg_pkg::PIN0_FN_BIT]};
    st_nxt.sw_done  = sw_done_w;
    st_nxt.pin_done = pin_done_w;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r           <= '0;
      st_r.cal_ctrl  <= acg_pkg::CAL_CTRL_RESET;
      st_r.gpio_ctrl <= acg_pkg::GPIO_CTRL_RESET;
      st_r.delay     <= acg_pkg::DELAY_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata         = st_r.rdata;
  assign reg_rvalid        = st_r.rvalid;
  assign cal_read_value    = st_r.cal_read;
  assign sys_gain_apply    = st_r.cal_apply[3];
  assign sys_offset_apply  = st_r.cal_apply[2];
  assign self_gain_apply   = st_r.cal_apply[1];
  assign self_offset_apply = st_r.cal_apply[0];
  assign pin1_is_gpio      = st_r.pin_fn[1];
  assign pin0_is_gpio      = st_r.pin_fn[0];
  assign sync_in           = st_r.sync_in;
  assign gpio_out          = st_r.gpio_out;
  assign gpio_oe           = st_r.gpio_oe;
  assign chan_switch_done  = st_r.sw_done;
  assign out_pin_done      = st_r.pin_done;
endmodule

// ==== tb/acg_config_bank_monitor.sv ====
// checker: shadows of host writes and the port relations they imply
`timescale 1ns/1ps
module acg_config_bank_monitor (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        reg_wr,
  input wire logic [1:0]  reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic [23:0] cal_if_value,
  input wire logic [23:0] cal_int_value,
  input wire logic [23:0] cal_read_value,
  input wire logic        sys_gain_apply,
  input wire logic        sys_offset_apply,
  input wire logic        self_gain_apply,
  input wire logic        self_offset_apply,
  input wire logic        pin1_is_gpio,
  input wire logic        pin0_is_gpio,
  input wire logic [2:0]  gpio_oe,
  input wire logic        chan_switch_start,
  input wire logic        chan_switch_done,
  input wire logic        out_pin_start,
  input wire logic        out_pin_done
);
  logic [4:0]  cal_r;
  logic [7:0]  io_r;
  logic [15:0] dly_r;
  logic [1:0]  age_r;
  // shadows follow writes; age hides the settle edges after reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cal_r <= acg_pkg::CAL_CTRL_RESET;
      io_r  <= acg_pkg::GPIO_CTRL_RESET;
      dly_r <= acg_pkg::DELAY_RESET;
      age_r <= 2'h0;
    end else begin
      if (reg_wr && reg_sel == acg_pkg::REG_CAL_CTRL) cal_r <= reg_wdata[4:0];
      if (reg_wr && reg_sel == acg_pkg::REG_GPIO_CTRL) io_r <= reg_wdata[7:0];
      if (reg_wr && reg_sel == acg_pkg::REG_DELAY) dly_r <= reg_wdata;
      if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || age_r != 2'h3);
  sequence sw_zero_s;
    chan_switch_start && dly_r[15:8] == 8'h00;
  endsequence
  sequence pin_zero_s;
    out_pin_start && dly_r[7:0] == 8'h00;
  endsequence
  cal_mux_a: assert property (cal_read_value ==
    ($past(cal_r[4]) ? $past(cal_if_value) : $past(cal_int_value))) else $error("cal mux");
  gain_apply_a: assert property ({sys_gain_apply, self_gain_apply} ==
    ~{$past(cal_r[3]), $past(cal_r[1])}) else $error("gain apply");
  offset_apply_a: assert property ({sys_offset_apply, self_offset_apply} ==
    ~{$past(cal_r[2]), $past(cal_r[0])}) else $error("offset apply");
  pin1_fn_a: assert property (pin1_is_gpio == $past(io_r[7]))
    else $error("pin1 function");
  pin0_fn_a: assert property (pin0_is_gpio == $past(io_r[6]))
    else $error("pin0 function");
  pad_enable_a: assert property (gpio_oe == ($past(io_r[5:3]) & {1'b1, $past(io_r[7:6])}))
    else $error("pad enable");
  sw_zero_a: assert property (sw_zero_s |-> ##[1:2] chan_switch_done)
    else $error("switch delay");
  pin_zero_a: assert property (pin_zero_s |-> ##[1:2] out_pin_done)
    else $error("pin delay");
endmodule
bind acg_config_bank acg_config_bank_monitor u_mon (
  .core_clk          (core_clk),
  .reset             (reset),
  .reg_wr            (reg_wr),
  .reg_sel           (reg_sel),
  .reg_wdata         (reg_wdata),
  .cal_if_value      (cal_if_value),
  .cal_int_value     (cal_int_value),
  .cal_read_value    (cal_read_value),
  .sys_gain_apply    (sys_gain_apply),
  .sys_offset_apply  (sys_offset_apply),
  .self_gain_apply   (self_gain_apply),
  .self_offset_apply (self_offset_apply),
  .pin1_is_gpio      (pin1_is_gpio),
  .pin0_is_gpio      (pin0_is_gpio),
  .gpio_oe           (gpio_oe),
  .chan_switch_start (chan_switch_start),
  .chan_switch_done  (chan_switch_done),
  .out_pin_start     (out_pin_start),
  .out_pin_done      (out_pin_done)
);

// ==== tb/acg_pad_model.sv ====
// board pads: follow the device where it drives, else the board level
`timescale 1ns/1ps
module acg_pad_model (
  input  wire logic [2:0] gpio_out,
  input  wire logic [2:0] gpio_oe,
  input  wire logic [2:0] board_level,
  output logic      [2:0] gpio_in
);
  // undriven pads never echo the device value
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board_level);
endmodule

// ==== tb/acg_config_bank_test.sv ====
// self-checking bench for the calibration, gpio and settle delay bank
`timescale 1ns/1ps
module acg_config_bank_test;
  localparam logic [1:0] CAL = acg_pkg::REG_CAL_CTRL;
  localparam logic [1:0] GP  = acg_pkg::REG_GPIO_CTRL;
  localparam logic [1:0] DL  = acg_pkg::REG_DELAY;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sync_pin_in = 1'b0;
  logic chan_switch_start = 1'b0, out_pin_start = 1'b0;
  logic [1:0] reg_sel = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [23:0] cal_if_value = 24'hA5C3E1, cal_int_value = 24'h1E3C5A, cal_read_value;
  logic reg_rvalid, sys_gain_apply, sys_offset_apply, self_gain_apply, self_offset_apply;
  logic pin1_is_gpio, pin0_is_gpio, sync_in, chan_switch_done, out_pin_done;
  logic [2:0] gpio_in, gpio_out, gpio_oe, board_level = 3'h6;
  int errors = 0, checks = 0, cycles = 0, base;
  acg_config_bank u_dut (
    .core_clk          (core_clk),
    .reset             (reset),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_sel           (reg_sel),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .reg_rvalid        (reg_rvalid),
    .cal_if_value      (cal_if_value),
    .cal_int_value     (cal_int_value),
    .cal_read_value    (cal_read_value),
    .sys_gain_apply    (sys_gain_apply),
    .sys_offset_apply  (sys_offset_apply),
    .self_gain_apply   (self_gain_apply),
    .self_offset_apply (self_offset_apply),
    .pin1_is_gpio      (pin1_is_gpio),
    .pin0_is_gpio      (pin0_is_gpio),
    .sync_pin_in       (sync_pin_in),
    .sync_in           (sync_in),
    .gpio_in           (gpio_in),
    .gpio_out          (gpio_out),
    .gpio_oe           (gpio_oe),
    .chan_switch_start (chan_switch_start),
    .chan_switch_done  (chan_switch_done),
    .out_pin_start     (out_pin_start),
    .out_pin_done      (out_pin_done)
  );
  acg_pad_model u_pad (
    .gpio_out    (gpio_out),
    .gpio_oe     (gpio_oe),
    .board_level (board_level),
    .gpio_in     (gpio_in)
  );
  always #50 core_clk = ~core_clk;
  // hang guard; the longest delay run is about 10.2k cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 15000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // write, then one more edge so derived outputs have landed
  task automatic wr(input logic [1:0] sel, input logic [15:0] data);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = data;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_sel = sel;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk("read", {7'h0, 1'b1, exp}, {7'h0, reg_rvalid, reg_rdata});
  endtask
  // one start pulse, then count edges until done shows
  task automatic run(input bit pin, output int n);
    n = 0;
    @(negedge core_clk);
    chan_switch_start = !pin;
    out_pin_start = pin;
    @(negedge core_clk);
    chan_switch_start = 1'b0;
    out_pin_start = 1'b0;
    while ((pin ? out_pin_done : chan_switch_done) !== 1'b1 && n < 11000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // reset values, every calibration code, pads, refusal, delays
  initial begin
    int n;
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    rd(CAL, 16'h001C);
    rd(GP, 16'h0046);
    for (int i = 0; i < 32; i++) begin
      wr(CAL, 16'(i));
      chk("apply", {20'h0, ~i[3:0]},
          {20'h0, sys_gain_apply, sys_offset_apply, self_gain_apply, self_offset_apply});
      chk("calread", i[4] ? cal_if_value : cal_int_value, cal_read_value);
    end
    wr(GP, 16'h00FD);
    chk("oe", 24'h7, {21'h0, gpio_oe});
    chk("out", 24'h5, {21'h0, gpio_out});
    chk("fn", 24'h3, {22'h0, pin1_is_gpio, pin0_is_gpio});
    rd(GP, 16'h00FD);
    wr(GP, 16'h00C1);
    chk("oe", 24'h0, {21'h0, gpio_oe});
    // released pads reach the read mux only after the two sync flops
    repeat (2) @(negedge core_clk);
    rd(GP, 16'h00C6);
    wr(GP, 16'h0038);
    chk("oe", 24'h4, {21'h0, gpio_oe});
    sync_pin_in = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("sync", 24'h1, {23'h0, sync_in});
    wr(GP, 16'h0080);
    repeat (2) @(negedge core_clk);
    chk("sync", 24'h0, {23'h0, sync_in});
    wr(2'h3, 16'hFFFF);
    rd(2'h3, 16'h0000);
    rd(DL, 16'h0000);
    run(1'b0, base);
    chk("zero", 24'h1, {23'h0, base <= 2});
    run(1'b1, n);
    chk("pinzero", 24'(base), 24'(n));
    wr(DL, 16'hFF03);
    rd(DL, 16'hFF03);
    run(1'b0, n);
    chk("swdly", 24'(base + 10200), 24'(n));
    run(1'b1, n);
    chk("pindly", 24'(base + 600), 24'(n));
    wrap_up();
  end
endmodule
